// >>> src/opd_top.sv
// Over-power detector: registers, power difference and event counting
`timescale 1ns/1ps
`default_nettype none
module opd_top
  import opd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic auto_power_control,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic report_valid,
  input wire opd_report_s report,
  input wire opd_meas_s meas,
  input wire logic [PWR_W-1:0] fixed_th,
  input wire logic ctrl_err_converged,
  output logic over_power,
  output logic tx_stop
);

  ////////////////////////////////////////////////////////////////
  logic rst_s1_q;
  logic rst_n_q;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////
  logic [7:0] cnt_limit_q;
  logic [7:0] slope_q;
  logic [7:0] offset_q;
  logic [7:0] duty_lim_q;
  logic [7:0] ctrl_q;
  logic [3:0] evt_cnt_q;

  // Writes only in auto power control; other modes leave registers unchanged
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cnt_limit_q <= RESET_VAL;
      slope_q <= RESET_VAL;
      offset_q <= RESET_VAL;
      duty_lim_q <= RESET_VAL;
      ctrl_q <= RESET_VAL;
    end else if (reg_wr && auto_power_control) begin
      if (reg_addr == ADDR_CNT_LIMIT) begin
        cnt_limit_q <= reg_wdata;
      end else if (reg_addr == ADDR_SLOPE) begin
        slope_q <= reg_wdata;
      end else if (reg_addr == ADDR_OFFSET) begin
        offset_q <= reg_wdata;
      end else if (reg_addr == ADDR_DUTY_LIM) begin
        duty_lim_q <= reg_wdata;
      end else if (reg_addr == ADDR_CTRL) begin
        ctrl_q <= reg_wdata;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      reg_rdata <= UNMAPPED_VAL;
    end else if (reg_rd) begin
      if (reg_addr == ADDR_CNT_LIMIT) begin
        reg_rdata <= cnt_limit_q;
      end else if (reg_addr == ADDR_EVT_COUNT) begin
        reg_rdata <= {evt_cnt_q, 4'h0};
      end else if (reg_addr == ADDR_SLOPE) begin
        reg_rdata <= slope_q;
      end else if (reg_addr == ADDR_OFFSET) begin
        reg_rdata <= offset_q;
      end else if (reg_addr == ADDR_DUTY_LIM) begin
        reg_rdata <= duty_lim_q;
      end else if (reg_addr == ADDR_CTRL) begin
        reg_rdata <= ctrl_q;
      end else begin
        reg_rdata <= UNMAPPED_VAL;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  logic [3:0] limit;
  logic det_on;
  logic masked;
  assign limit = cnt_limit_q[CNT_MSB:CNT_LSB];
  assign det_on = ctrl_q[CTRL_EN_BIT] && (limit != CNT_ZERO) && auto_power_control;
  assign masked = ctrl_q[CTRL_MASK_BIT] && !ctrl_err_converged;

  // Sense resistance in quarter ohms: 1,2,4,8
  logic [3:0] rcs_q4;
  always_comb begin
    rcs_q4 = 4'h1 << ctrl_q[CTRL_RCS_MSB:CTRL_RCS_LSB];
  end

  ////////////////////////////////////////////////////////////////
  opd_state_e st_q;
  opd_report_s rep_q;
  opd_meas_s meas_q;
  logic [PWR_W+7:0] tx_pwr_q;
  logic [PWR_W+7:0] diff_q;
  logic [PWR_W+7:0] thresh;

  opd_thresh u_thresh (
    .duty(meas_q.duty),
    .slope(slope_q),
    .offset(offset_q),
    .duty_lim(duty_lim_q),
    .fixed_th(fixed_th),
    .thresh(thresh)
  );

  // Current = Vsense / (gain * R); R in quarter ohms, so scale by 4
  logic [PWR_W+7:0] i_bridge;
  always_comb begin
    i_bridge = (PWR_W+8)'(({8'h00, meas_q.sense_v} << 2) / (24'(SENSE_GAIN) * 24'(rcs_q4)));
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_q <= OPD_IDLE;
      rep_q <= '0;
      meas_q <= '0;
      tx_pwr_q <= '0;
      diff_q <= '0;
    end else begin
      case (st_q)
        OPD_IDLE: begin
          // Only status packets of the right header start a check
          if (report_valid && report.header == STATUS_HDR && det_on) begin
            rep_q <= report;
            meas_q <= meas;
            st_q <= OPD_CALC;
          end
        end
        OPD_CALC: begin
          tx_pwr_q <= (PWR_W+8)'(32'(i_bridge[PWR_W-1:0]) * 32'(meas_q.bridge_v) >> PWR_W);
          st_q <= OPD_CMP;
        end
        OPD_CMP: begin
          // Negative difference saturates at zero
          if (tx_pwr_q > (PWR_W+8)'(rep_q.rx_power)) begin
            diff_q <= tx_pwr_q - (PWR_W+8)'(rep_q.rx_power);
          end else begin
            diff_q <= '0;
          end
          st_q <= OPD_TRIP;
        end
        default: begin
          st_q <= OPD_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  logic exceed;
  assign exceed = (st_q == OPD_TRIP) && (diff_q > thresh) && det_on && !masked;

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      evt_cnt_q <= CNT_ZERO;
    end else if (!det_on) begin
      evt_cnt_q <= CNT_ZERO;
    end else if (exceed && evt_cnt_q != limit) begin
      evt_cnt_q <= evt_cnt_q + CNT_ONE;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      over_power <= 1'b0;
    end else begin
      over_power <= exceed;
    end
  end

  // Stop is sticky until detection is disabled or reset
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tx_stop <= 1'b0;
    end else if (!det_on) begin
      tx_stop <= 1'b0;
    end else if (exceed && (evt_cnt_q + CNT_ONE) >= limit) begin
      tx_stop <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// >>> include/opd_pkg.sv
// Package: constants, types and register map of the over-power detector
package opd_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int DUTY_W = 10;
  localparam int PWR_W = 16;

  localparam logic [7:0] ADDR_CNT_LIMIT = 8'h32;
  localparam logic [7:0] ADDR_EVT_COUNT = 8'h39;
  localparam logic [7:0] ADDR_SLOPE = 8'h3B;
  localparam logic [7:0] ADDR_OFFSET = 8'h3C;
  localparam logic [7:0] ADDR_DUTY_LIM = 8'h3E;
  localparam logic [7:0] ADDR_CTRL = 8'h3F;

  localparam logic [7:0] RESET_VAL = 8'h00;
  localparam logic [7:0] UNMAPPED_VAL = 8'h00;

  localparam int CNT_LSB = 4;
  localparam int CNT_MSB = 7;
  localparam int CTRL_EN_BIT = 3;
  localparam int CTRL_MASK_BIT = 2;
  localparam int CTRL_RCS_LSB = 0;
  localparam int CTRL_RCS_MSB = 1;
  localparam int DUTY_HI_LSB = 2;

  // Header code of receiver status packet carrying its power
  localparam logic [7:0] STATUS_HDR = 8'h04;

  // Amplifier gain applied to sensed current, shift applied to slope term
  localparam int SENSE_GAIN = 10;
  localparam int SLOPE_SHIFT = 6;

  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;

  typedef enum logic [1:0] {
    OPD_IDLE = 2'b00,
    OPD_CALC = 2'b01,
    OPD_CMP = 2'b11,
    OPD_TRIP = 2'b10
  } opd_state_e;

  typedef struct packed {
    logic [7:0] header;
    logic [PWR_W-1:0] rx_power;
  } opd_report_s;

  typedef struct packed {
    logic [DUTY_W-1:0] duty;
    logic [PWR_W-1:0] bridge_v;
    logic [PWR_W-1:0] sense_v;
  } opd_meas_s;

endpackage

// >>> src/opd_thresh.sv
// Threshold calculator for the over-power detector
`timescale 1ns/1ps
`default_nettype none
module opd_thresh
  import opd_pkg::*;
(
  input wire logic [DUTY_W-1:0] duty,
  input wire logic [7:0] slope,
  input wire logic [7:0] offset,
  input wire logic [7:0] duty_lim,
  input wire logic [PWR_W-1:0] fixed_th,
  output logic [PWR_W+7:0] thresh
);
  logic [PWR_W+7:0] lin;
  always_comb begin
    // Units of offset code; slope pre-scaled by 1/64 of duty code
    lin = (PWR_W+8)'((18'(slope) * 18'(duty)) >> SLOPE_SHIFT) + (PWR_W+8)'(offset);
    if (duty[DUTY_W-1:DUTY_HI_LSB] <= duty_lim) begin
      thresh = (PWR_W+8)'(fixed_th);
    end else begin
      thresh = lin;
    end
  end
endmodule
`default_nettype wire

// >>> verif/opd_rx_model.sv
// Receiver model sending power reports
`timescale 1ns/1ps
`default_nettype none
module opd_rx_model
  import opd_pkg::*;
(
  input wire logic ref_clk,
  output logic report_valid,
  output opd_report_s report
);
  logic busy = 1'b0;
  initial begin
    report_valid = 1'b0;
    report = '0;
  end
  // Idle bus toggles, stale data never looks valid
  always @(negedge ref_clk) begin
    if (!busy) report <= ~report;
  end
  task automatic send(input logic [7:0] hdr, input logic [PWR_W-1:0] pwr);
    busy = 1'b1;
    @(negedge ref_clk);
    report_valid <= 1'b1;
    report <= '{hdr, pwr};
    @(negedge ref_clk);
    report_valid <= 1'b0;
    busy = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> verif/opd_top_chk.sv
// Port checker for the over-power detector
`timescale 1ns/1ps
`default_nettype none
module opd_top_chk
  import opd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic auto_power_control,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic report_valid,
  input wire opd_report_s report,
  input wire logic ctrl_err_converged,
  input wire logic over_power,
  input wire logic tx_stop
);
  logic [3:0] ctl_q;
  logic [3:0] lim_q;
  logic wr_ok;
  assign wr_ok = reg_wr && auto_power_control;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl_q <= 4'h0;
      lim_q <= 4'h0;
    end else if (wr_ok) begin
      if (reg_addr == ADDR_CTRL) ctl_q <= reg_wdata[3:0];
      if (reg_addr == ADDR_CNT_LIMIT) lim_q <= reg_wdata[7:4];
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  op_pulse_a: assert property (over_power |=> !over_power)
    else $error("over_power longer than one cycle");
  op_cause_a: assert property (over_power |-> $past(report_valid, 4) &&
    $past(report.header, 4) == STATUS_HDR) else $error("over_power without report");
  op_enable_a: assert property (over_power |-> ctl_q[3] && lim_q != CNT_ZERO)
    else $error("over_power while disabled");
  op_mask_a: assert property (over_power |-> !(ctl_q[2] && !$past(ctrl_err_converged, 1)))
    else $error("over_power while masked");
  stop_rise_a: assert property ($rose(tx_stop) |-> over_power)
    else $error("tx_stop rose without event");
  stop_hold_a: assert property (tx_stop && ctl_q[3] && lim_q != CNT_ZERO &&
    auto_power_control |=> tx_stop) else $error("tx_stop dropped");
  stop_clear_a: assert property (wr_ok && reg_addr == ADDR_CTRL && !reg_wdata[3]
    |-> ##[1:4] !tx_stop) else $error("tx_stop kept after disable");
  rd_ctrl_a: assert property (reg_rd && reg_addr == ADDR_CTRL |=> ##[0:1]
    reg_rdata[3:0] == ctl_q) else $error("control readback wrong");
endmodule
bind opd_top opd_top_chk i_opd_top_chk (.*);
`default_nettype wire

// >>> verif/opd_top_tb.sv
// Self-checking bench for the over-power detector
`timescale 1ns/1ps
`default_nettype none
module opd_top_tb;
  import opd_pkg::*;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic auto_power_control = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic report_valid;
  logic over_power;
  logic tx_stop;
  opd_report_s report;
  opd_meas_s meas = '0;
  logic [15:0] fixed_th = 16'h0064;
  logic ctrl_err_converged = 1'b1;
  logic [7:0] exp_q[$];
  logic [4:0] rv_sh = 5'h00;
  logic [1:0] rd_sh = 2'h0;
  logic [7:0] adr[7] = '{ADDR_CNT_LIMIT, ADDR_EVT_COUNT, ADDR_SLOPE, ADDR_OFFSET,
    ADDR_DUTY_LIM, ADDR_CTRL, 8'h40};
  int bad_count = 0;
  int n_compared = 0;
  int seed = 32'h8cb7;
  logic [7:0] rnd;
  always #50 ref_clk = ~ref_clk;
  opd_rx_model i_opd_rx_model (.ref_clk, .report_valid, .report);
  opd_top i_opd_top (.ref_clk, .arst_n, .auto_power_control, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .report_valid, .report, .meas, .fixed_th, .ctrl_err_converged,
    .over_power, .tx_stop);
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    exp_q.push_back(e);
    @(negedge ref_clk);
    reg_rd = 1'b0;
    repeat (2) @(negedge ref_clk);
  endtask
  // Tx power: 1000*4/(10*Rq4) scaled by full bridge voltage
  task automatic rep(input logic [7:0] h, input logic [15:0] p, input logic [9:0] d,
    input logic [1:0] e);
    meas = '{d, 16'hffff, 16'd1000};
    exp_q.push_back({6'h00, e});
    i_opd_rx_model.send(h, p);
    repeat (6) @(negedge ref_clk);
  endtask
  always @(posedge ref_clk) begin
    rv_sh <= {rv_sh[3:0], report_valid};
    rd_sh <= {rd_sh[0], reg_rd};
  end
  always @(negedge ref_clk) begin
    if (rd_sh[1]) chk(reg_rdata, exp_q.pop_front());
    if (rv_sh[3]) chk({6'h00, over_power, tx_stop}, exp_q.pop_front());
  end
  initial begin
    repeat (3) @(negedge ref_clk);
    arst_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    foreach (adr[i]) rd_reg(adr[i], RESET_VAL);
    rnd = 8'($random(seed));
    wr_reg(ADDR_SLOPE, rnd);
    rd_reg(ADDR_SLOPE, rnd);
    auto_power_control = 1'b0;
    wr_reg(ADDR_SLOPE, ~rnd);
    auto_power_control = 1'b1;
    rd_reg(ADDR_SLOPE, rnd);
    wr_reg(ADDR_CNT_LIMIT, 8'h20);
    wr_reg(ADDR_SLOPE, 8'h00);
    wr_reg(ADDR_OFFSET, 8'h32);
    wr_reg(ADDR_DUTY_LIM, 8'h80);
    rep(STATUS_HDR, 16'd0, 10'h000, 2'b00);
    wr_reg(ADDR_CTRL, 8'h08);
    rd_reg(ADDR_CTRL, 8'h08);
    rep(8'h05, 16'd0, 10'h000, 2'b00);
    rep(STATUS_HDR, 16'd350, 10'h000, 2'b00);
    rep(STATUS_HDR, 16'd0, 10'h000, 2'b10);
    rd_reg(ADDR_EVT_COUNT, 8'h10);
    rep(STATUS_HDR, 16'd350, 10'h3ff, 2'b00);
    rep(STATUS_HDR, 16'd340, 10'h3ff, 2'b11);
    wr_reg(ADDR_CTRL, 8'h00);
    rd_reg(ADDR_EVT_COUNT, 8'h00);
    wr_reg(ADDR_CTRL, 8'h0c);
    ctrl_err_converged = 1'b0;
    rep(STATUS_HDR, 16'd0, 10'h000, 2'b00);
    ctrl_err_converged = 1'b1;
    rep(STATUS_HDR, 16'd0, 10'h000, 2'b10);
    wr_reg(ADDR_CTRL, 8'h0b);
    rep(STATUS_HDR, 16'd0, 10'h000, 2'b00);
    wr_reg(ADDR_CNT_LIMIT, 8'h00);
    wr_reg(ADDR_CTRL, 8'h08);
    rep(STATUS_HDR, 16'd0, 10'h000, 2'b00);
    report_and_stop();
  end
  // Run needs about 160 cycles
  initial begin
    #1_000_000;
    bad_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
